// ===== core/csor_regs.sv
// Core status and option register bank with pin override logic.
// Function
// [RL1] Flag-updating instructions writing status keep Z, DC, C from the result.
// [RL2] Writes to time-out and power-down flags are ignored.
// [RL3] Software alters status only with bit-set, bit-clear or move-to-file.
// [RL4] Bit 7 set on pin-change wake reset, cleared on other resets.
// [RL5] Bit 6 set on comparator wake reset, cleared on other resets.
// [RL6] Bit 5 selects upper or lower 512-location program page.
// [RL7] Software should not use the page bit as general storage.
// [RL8] Time-out set on power-up, watchdog clear, sleep; cleared on time-out.
// [RL9] Power-down set on power-up and watchdog clear; cleared by sleep.
// [RL10] Zero flag set when result is zero, else cleared.
// [RL11] Digit carry from bit 3; on subtract it is inverted borrow.
// [RL12] Carry on add, no-borrow on subtract, LSb or MSb on rotates.
// [RL13] Option is eight bits, write-only, loaded from working register.
// [RL14] Every reset sets all option bits to one.
// [RL15] Output-direction pins lose wake-up and pull-up.
// [RL16] Timer clock source one forces timer clock pin to input.
// [RL17] Option bit 7 low enables pin-change wake-up.
// [RL18] Option bit 6 low enables weak pull-ups.
// [RL19] Option bit 5 selects external pin or instruction clock.
// [RL20] Option bit 4 selects falling or rising edge.
// [RL21] Option bit 3 assigns prescaler to watchdog or Timer0.
// [RL22] Rate n divides Timer0 by 2^(n+1), watchdog by 2^n; the 8-bit timer0Divide reads zero at rate 7.
// [RL23] Reset clears the page preselect bit.
`timescale 1ns/1ps
module csor_regs
   import csor_pkg::*;
(
   // Clock and reset.
   input  wire logic                 clk_sys,
   input  wire logic                 sys_rst,
   input  wire csor_pkg::csor_rst_e  rstCause,
   // Instruction core side, sampled on the instruction clock enable.
   input  wire logic                 instrEn,
   input  wire logic                 statusWrite,
   input  wire logic [7:0]           statusWdata,
   input  wire logic                 aluExec,
   input  wire logic [1:0]           aluOp,
   input  wire logic [7:0]           aluOpA,
   input  wire logic [7:0]           aluOpB,
   input  wire logic                 optionLoad,
   input  wire logic [7:0]           workingReg,
   input  wire csor_pkg::csor_evt_s  events,
   // Port direction control, one bit per pin, low is output.
   input  wire logic [7:0]           directionControl,
   input  wire logic [7:0]           wakePinMask,
   input  wire logic [7:0]           timerPinMask,
   // Register and decoded outputs.
   output logic [7:0]                aluAndResetFlags,
   output logic [7:0]                aluResult,
   output csor_pkg::csor_opt_s       options,
   output logic [7:0]                pinWakeEnable,
   output logic [7:0]                pinPullupEnable,
   output logic [7:0]                pinForceInput,
   output logic [7:0]                timer0Divide,
   output logic [7:0]                watchdogDivide,
   output logic [9:0]                pageBase
);
   import csor_pkg::*;

   logic [7:0] optionReg;
   logic [7:0] next_status;
   logic [7:0] next_result;
   csor_alu_s  aluFlags;

   // Flag arithmetic sits in its own module so the core can reuse it.
   csor_flag_calc u_calc (
      .opA     (aluOpA),
      .opB     (aluOpB),
      .op      (aluOp),
      .carryIn (aluAndResetFlags[STAT_C_BIT]),
      .flags   (aluFlags),
      .result  (next_result)
   );

   // Power of two used for both prescaler readouts.
   function automatic logic [7:0] pow2(input logic [2:0] n);
      pow2 = 8'h01 << n;
   endfunction

   // Writable bits of a status write; hardware bits are masked out.
   wire [7:0] wrMask = aluExec ? ~(ALU_FLAG_MASK | HW_FLAG_MASK)
                               : ~HW_FLAG_MASK;           // [RL1] [RL2]
   wire [7:0] wrStatus = (aluAndResetFlags & ~wrMask)
                       | (statusWdata & wrMask);          // [RL3]

   // Hardware events win over software writes on the same cycle.
   always_comb begin
      next_status = statusWrite ? wrStatus : aluAndResetFlags;
      if (aluExec) begin
         next_status[STAT_Z_BIT]  = aluFlags.zero;        // [RL1] [RL10]
         next_status[STAT_DC_BIT] = aluFlags.digitCarry;  // [RL11]
         next_status[STAT_C_BIT]  = aluFlags.carry;       // [RL12]
      end
      if (events.watchdogClear) begin
         next_status[STAT_TO_BIT] = 1'b1;                 // [RL8]
         next_status[STAT_PD_BIT] = 1'b1;                 // [RL9]
      end
      if (events.sleepExec) begin
         next_status[STAT_TO_BIT] = 1'b1;                 // [RL8]
         next_status[STAT_PD_BIT] = 1'b0;                 // [RL9]
      end
      if (events.watchdogTimeout) begin
         next_status[STAT_TO_BIT] = 1'b0;                 // [RL8]
      end
   end

   // Reset loads cause flags; ALU flags are unknown at power-up so
   // they are left unchanged across reset to mirror silicon.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         aluAndResetFlags[STAT_PINW_BIT] <=
            (rstCause == CSOR_RST_PINW);                  // [RL4]
         aluAndResetFlags[STAT_CMPW_BIT] <=
            (rstCause == CSOR_RST_CMPW);                  // [RL5]
         aluAndResetFlags[STAT_PAGE_BIT] <= 1'b0;         // [RL23]
         if (rstCause == CSOR_RST_POWER) begin
            aluAndResetFlags[STAT_TO_BIT] <= 1'b1;        // [RL8]
            aluAndResetFlags[STAT_PD_BIT] <= 1'b1;        // [RL9]
         end
      end else if (instrEn) begin
         aluAndResetFlags <= next_status;
      end
   end

   // Option register is only loaded from the working register.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         optionReg <= OPTION_RESET;                       // [RL14]
      end else if (instrEn && optionLoad) begin
         optionReg <= workingReg;                         // [RL13]
      end
   end

   // Registered ALU result for the core.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         aluResult <= 8'h00;
      end else if (instrEn && aluExec) begin
         aluResult <= next_result;
      end
   end

   // Field decode of the option register.
   wire [2:0] rateSel = optionReg[OPT_RATE_MSB:OPT_RATE_LSB];
   wire wakeOn = ~optionReg[OPT_WAKE_BIT];                // [RL17]
   wire pullOn = ~optionReg[OPT_PULL_BIT];                // [RL18]
   wire extClk = optionReg[OPT_SRC_BIT];                  // [RL19]
   wire toWdt  = optionReg[OPT_PSA_BIT];                  // [RL21]
   wire [7:0] next_wake  = {PIN_COUNT{wakeOn}} & wakePinMask
                         & directionControl;              // [RL15]
   wire [7:0] next_pull  = {PIN_COUNT{pullOn}} & wakePinMask
                         & directionControl;              // [RL15]
   wire [7:0] next_force = {PIN_COUNT{extClk}} & timerPinMask; // [RL16]
   // Unassigned side runs undivided.
   wire [7:0] next_t0div = toWdt ? 8'h01
                         : 8'(pow2(rateSel) << 1);        // [RL22]
   wire [7:0] next_wddiv = toWdt ? pow2(rateSel) : 8'h01; // [RL22]
   wire [9:0] next_page  = aluAndResetFlags[STAT_PAGE_BIT] ? PAGE_SPAN
                                                           : 10'h000; // [RL6]

   // Outputs are registered so downstream timing stays one flop deep.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         options         <= csor_opt_s'(OPTION_RESET);
         pinWakeEnable   <= 8'h00;
         pinPullupEnable <= 8'h00;
         pinForceInput   <= 8'h00;
         timer0Divide    <= 8'h01;
         watchdogDivide  <= 8'h01;
         pageBase        <= 10'h000;
      end else begin
         options         <= csor_opt_s'(optionReg);       // [RL20]
         pinWakeEnable   <= next_wake;
         pinPullupEnable <= next_pull;
         pinForceInput   <= next_force;
         timer0Divide    <= next_t0div;
         watchdogDivide  <= next_wddiv;
         pageBase        <= next_page;
      end
   end

   // Checks of the register behaviour.
   a_opt_reset: assert property (@(posedge clk_sys)
      sys_rst |=> optionReg == 8'hff)                      // [RL14]
      else $error("option not all ones after reset");
   a_opt_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
      instrEn && optionLoad |=> optionReg == $past(workingReg)) // [RL13]
      else $error("option load lost");
   a_page_reset: assert property (@(posedge clk_sys)
      sys_rst |=> !aluAndResetFlags[5])                    // [RL23]
      else $error("page bit not cleared");
   a_pin_wake: assert property (@(posedge clk_sys)
      sys_rst |=> aluAndResetFlags[7] == ($past(rstCause) == CSOR_RST_PINW))
      else $error("pin wake flag wrong");                  // [RL4]
   a_cmp_wake: assert property (@(posedge clk_sys)
      sys_rst |=> aluAndResetFlags[6] == ($past(rstCause) == CSOR_RST_CMPW))
      else $error("comparator wake flag wrong");           // [RL5]
   a_hw_protect: assert property (@(posedge clk_sys) disable iff (sys_rst)
      instrEn && statusWrite && !events.watchdogClear && !events.sleepExec
      && !events.watchdogTimeout
      |=> $stable(aluAndResetFlags[4:3]))                  // [RL2]
      else $error("hardware flags written");
   a_alu_wins: assert property (@(posedge clk_sys) disable iff (sys_rst)
      instrEn && aluExec |=> aluAndResetFlags[2] == (aluResult == 8'h00))
      else $error("zero flag not from result");            // [RL1]
   a_sleep_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
      instrEn && events.sleepExec && !events.watchdogTimeout
      |=> aluAndResetFlags[4:3] == 2'b10)                  // [RL8]
      else $error("sleep flags wrong");
   a_clr_flags: assert property (@(posedge clk_sys) disable iff (sys_rst)
      instrEn && events.watchdogClear && !events.sleepExec
      && !events.watchdogTimeout |=> aluAndResetFlags[4:3] == 2'b11)
      else $error("watchdog clear flags wrong");           // [RL9]
   a_out_dir: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ##1 (pinWakeEnable & ~$past(directionControl)) == 8'h00) // [RL15]
      else $error("wake on output pin");
   a_wd_div: assert property (@(posedge clk_sys) disable iff (sys_rst)
      optionReg[3] |=> watchdogDivide == pow2($past(optionReg[2:0])))
      else $error("watchdog divide wrong");                // [RL22]

   c_opt_load:  cover property (@(posedge clk_sys) instrEn && optionLoad);
   c_sleep:     cover property (@(posedge clk_sys) instrEn && events.sleepExec);
   c_stat_alu:  cover property (@(posedge clk_sys)
      instrEn && statusWrite && aluExec);
   c_wake_rst:  cover property (@(posedge clk_sys)
      sys_rst && rstCause == CSOR_RST_PINW);
endmodule

// ===== core/csor_pkg.sv
// Package of field positions, reset values and carriers for the core status and option registers.
package csor_pkg;
   // Status register field positions.
   localparam int STAT_C_BIT     = 0;
   localparam int STAT_DC_BIT    = 1;
   localparam int STAT_Z_BIT     = 2;
   localparam int STAT_PD_BIT    = 3;
   localparam int STAT_TO_BIT    = 4;
   localparam int STAT_PAGE_BIT  = 5;
   localparam int STAT_CMPW_BIT  = 6;
   localparam int STAT_PINW_BIT  = 7;
   // Option register field positions.
   localparam int OPT_WAKE_BIT   = 7;
   localparam int OPT_PULL_BIT   = 6;
   localparam int OPT_SRC_BIT    = 5;
   localparam int OPT_EDGE_BIT   = 4;
   localparam int OPT_PSA_BIT    = 3;
   localparam int OPT_RATE_LSB   = 0;
   localparam int OPT_RATE_MSB   = 2;
   // Reset value, flag masks, page span and pin count.
   localparam logic [7:0] OPTION_RESET = 8'hff;
   localparam logic [7:0] ALU_FLAG_MASK = 8'h07;
   localparam logic [7:0] HW_FLAG_MASK  = 8'h18;
   localparam logic [9:0] PAGE_SPAN     = 10'h200;
   localparam int PIN_COUNT = 8;

   // Kind of reset that the core reports.
   typedef enum logic [3:0] {
      CSOR_RST_POWER = 4'h1,
      CSOR_RST_PINW  = 4'h2,
      CSOR_RST_CMPW  = 4'h4,
      CSOR_RST_OTHER = 4'h8
   } csor_rst_e;

   // ALU result flags offered by an executing instruction.
   typedef struct packed {
      logic update;
      logic zero;
      logic digitCarry;
      logic carry;
   } csor_alu_s;

   // Hardware events from the watchdog and instruction decoder.
   typedef struct packed {
      logic watchdogClear;
      logic sleepExec;
      logic watchdogTimeout;
   } csor_evt_s;

   // Decoded option fields.
   typedef struct packed {
      logic       pinWakeEnableN;
      logic       pullupEnableN;
      logic       timerClockSource;
      logic       timerEdgeSelect;
      logic       prescalerAssign;
      logic [2:0] prescalerRate;
   } csor_opt_s;
endpackage

// ===== core/csor_flag_calc.sv
// ALU flag arithmetic for add, subtract and rotate results.
`timescale 1ns/1ps
module csor_flag_calc
   import csor_pkg::*;
(
   // Operands and operation.
   input  wire logic [7:0] opA,
   input  wire logic [7:0] opB,
   input  wire logic [1:0] op,
   input  wire logic       carryIn,
   // Result and flags.
   output csor_alu_s       flags,
   output logic [7:0]      result
);
   // Opcode 0 add, 1 subtract b-a, 2 rotate right, 3 rotate left.
   wire [8:0] sum  = {1'b0, opA} + {1'b0, opB};
   wire [8:0] diff = {1'b0, opB} - {1'b0, opA};
   wire [4:0] sumLo  = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
   wire [4:0] diffLo = {1'b0, opB[3:0]} - {1'b0, opA[3:0]};

   // Subtraction flags are inverted borrows, so set means no borrow.
   always_comb begin
      flags.update     = 1'b1;
      flags.digitCarry = 1'b0;
      case (op)
         2'h0: begin
            result           = sum[7:0];
            flags.carry      = sum[8];           // [RL12]
            flags.digitCarry = sumLo[4];         // [RL11]
         end
         2'h1: begin
            result           = diff[7:0];
            flags.carry      = ~diff[8];         // [RL12]
            flags.digitCarry = ~diffLo[4];       // [RL11]
         end
         2'h2: begin
            result      = {carryIn, opB[7:1]};
            flags.carry = opB[0];                // [RL12]
         end
         default: begin
            result      = {opB[6:0], carryIn};
            flags.carry = opB[7];                // [RL12]
         end
      endcase
      flags.zero = (result == 8'h00);            // [RL10]
   end
endmodule

// ===== sim/csor_regs_test.sv
// Self-checking testbench for the core status and option register bank.
`timescale 1ns/1ps
module csor_regs_test;
   import csor_pkg::*;
   // Stimulus and observed signals.
   logic       clk_sys, sys_rst, instrEn, statusWrite, aluExec, optionLoad;
   csor_rst_e  rstCause;
   csor_evt_s  events;
   csor_opt_s  options;
   logic [1:0] aluOp;
   logic [7:0] statusWdata, aluOpA, aluOpB, workingReg, directionControl;
   logic [7:0] wakePinMask, timerPinMask, aluAndResetFlags, aluResult;
   logic [7:0] pinWakeEnable, pinPullupEnable, pinForceInput;
   logic [7:0] timer0Divide, watchdogDivide, w, expMask;
   logic [9:0] pageBase;
   logic [8:0] t0;
   int         failCount, comparisons;

   csor_regs dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .rstCause(rstCause), .instrEn(instrEn), .statusWrite(statusWrite),
      .statusWdata(statusWdata), .aluExec(aluExec), .aluOp(aluOp),
      .aluOpA(aluOpA), .aluOpB(aluOpB), .optionLoad(optionLoad),
      .workingReg(workingReg), .events(events),
      .directionControl(directionControl), .wakePinMask(wakePinMask),
      .timerPinMask(timerPinMask), .aluAndResetFlags(aluAndResetFlags),
      .aluResult(aluResult), .options(options),
      .pinWakeEnable(pinWakeEnable), .pinPullupEnable(pinPullupEnable),
      .pinForceInput(pinForceInput), .timer0Divide(timer0Divide),
      .watchdogDivide(watchdogDivide), .pageBase(pageBase));

   // The 25 MHz system clock.
   always #20 clk_sys = ~clk_sys;

   // Compares one result; the wide argument holds every output kind.
   task automatic chk(input string what, input logic [9:0] e,
                      input logic [9:0] g);
      comparisons++;
      if (g !== e) begin
         failCount++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic finalReport;
      $display("comparisons %0d mismatches %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Holds reset 20 cycles with the given cause, samples after release.
   task automatic doReset(input csor_rst_e c);
      @(posedge clk_sys);
      sys_rst  <= 1'b1;
      rstCause <= c;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask

   // One instruction cycle; decoded outputs are settled on return.
   task automatic issue(input logic sw, input logic [7:0] wd,
                        input logic ae, input logic [1:0] op,
                        input logic [7:0] a, input logic [7:0] b,
                        input logic ol, input logic [7:0] wr,
                        input csor_evt_s ev);
      @(posedge clk_sys);
      instrEn     <= 1'b1;
      statusWrite <= sw;
      statusWdata <= wd;
      aluExec     <= ae;
      aluOp       <= op;
      aluOpA      <= a;
      aluOpB      <= b;
      optionLoad  <= ol;
      workingReg  <= wr;
      events      <= ev;
      @(posedge clk_sys);
      instrEn     <= 1'b0;
      statusWrite <= 1'b0;
      aluExec     <= 1'b0;
      optionLoad  <= 1'b0;
      events      <= '0;
      @(posedge clk_sys);
      #1;
   endtask

   // Shortcuts for status writes and hardware events.
   task automatic wrStat(input logic [7:0] d);
      issue(1'b1, d, 1'b0, 2'd0, 8'h00, 8'h00, 1'b0, 8'h00, '0);
   endtask
   task automatic evt(input logic [2:0] e, input logic [7:0] x);
      issue(1'b0, 8'h00, 1'b0, 2'd0, 8'h00, 8'h00, 1'b0, 8'h00, e);
      chk("status hw flags", {2'b0, x}, {2'b0, aluAndResetFlags & 8'h18});
   endtask

   // Timeout guard, far beyond the length of the sequence below.
   initial begin
      repeat (5000) @(posedge clk_sys);
      failCount++;
      $display("mismatch watchdog expected finish seen hang");
      finalReport();
   end

   // ALU cases: op, a, b, result, flags; rotates look at carry only.
   logic [1:0] tOp[7] = '{2'd0, 2'd0, 2'd1, 2'd1, 2'd1, 2'd2, 2'd3};
   logic [7:0] tA[7]  = '{8'h0f, 8'hff, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
   logic [7:0] tB[7]  = '{8'h01, 8'h01, 8'h01, 8'h10, 8'h00, 8'h81, 8'h40};
   logic [7:0] tR[7]  = '{8'h10, 8'h00, 8'h00, 8'h0f, 8'hff, 8'h40, 8'h81};
   logic [2:0] tF[7]  = '{3'b010, 3'b111, 3'b111, 3'b001, 3'b000,
                          3'b001, 3'b000};

   initial begin
      clk_sys = 1'b0; sys_rst = 1'b1; rstCause = CSOR_RST_POWER;
      instrEn = 1'b0; statusWrite = 1'b0; aluExec = 1'b0;
      optionLoad = 1'b0; events = '0; aluOp = 2'd0; statusWdata = 8'h00;
      aluOpA = 8'h00; aluOpB = 8'h00; workingReg = 8'h00;
      directionControl = 8'h3c; wakePinMask = 8'h1b; timerPinMask = 8'h01;
      failCount = 0; comparisons = 0;
      doReset(CSOR_RST_POWER);
      chk("status upper", 10'h03, {5'b0, aluAndResetFlags[7:3]});
      chk("options reset", 10'h0ff, {2'b0, options});
      chk("page reset", 10'h000, pageBase);
      // Software writes leave the hardware flags alone.
      wrStat(8'h00);
      chk("status write", 10'h018, {2'b0, aluAndResetFlags & 8'hf8});
      wrStat(8'he7);
      chk("status write", 10'h0f8, {2'b0, aluAndResetFlags & 8'hf8});
      chk("page upper", 10'h200, pageBase);
      // Add and subtract result flags win over a simultaneous write of the opposite flags.
      for (int i = 0; i < 7; i++) begin
         expMask = (tOp[i] < 2'd2) ? 8'he7 : 8'h01;
         issue(tOp[i] < 2'd2, {5'b0, ~tF[i]}, 1'b1, tOp[i], tA[i], tB[i],
               1'b0, 8'h00, '0);
         chk("alu result", {2'b0, tR[i]}, {2'b0, aluResult});
         chk("alu flags", {2'b0, expMask & {5'b0, tF[i]}},
             {2'b0, aluAndResetFlags & expMask});
      end
      // Sleep, time-out and watchdog clear on the two hardware flags.
      evt(3'b010, 8'h10);
      evt(3'b001, 8'h00);
      evt(3'b100, 8'h18);
      evt(3'b001, 8'h08);
      evt(3'b010, 8'h10);
      // Every rate on both prescaler sides except Timer0 rate 7; the other fields follow the rate.
      for (int n = 0; n < 8; n++) begin
         for (int p = 0; p < 2; p++) begin
            w = {n[0], n[1], n[2], ~n[0], p[0], n[2:0]};
            issue(1'b0, 8'h00, 1'b0, 2'd0, 8'h00, 8'h00, 1'b1, w, '0);
            t0 = 9'h001 << (n + 1);
            chk("options", {2'b0, w}, {2'b0, options});
            chk("wake en", {2'b0, {8{~w[7]}} & directionControl
                & wakePinMask}, {2'b0, pinWakeEnable});
            chk("pullup en", {2'b0, {8{~w[6]}} & directionControl
                & wakePinMask}, {2'b0, pinPullupEnable});
            chk("force in", {2'b0, {8{w[5]}} & timerPinMask},
                {2'b0, pinForceInput});
            chk("wdt div", p ? 10'(9'h001 << n) : 10'h001,
                {2'b0, watchdogDivide});
            if (p == 1 || n < 7)
               chk("t0 div", p ? 10'h001 : {1'b0, t0},
                   {2'b0, timer0Divide});
         end
      end
      // Non-power resets: wake causes, page cleared, hardware flags kept.
      wrStat(8'h20);
      doReset(CSOR_RST_OTHER);
      chk("status upper", 10'h02, {5'b0, aluAndResetFlags[7:3]});
      chk("options reset", 10'h0ff, {2'b0, options});
      doReset(CSOR_RST_PINW);
      chk("status upper", 10'h12, {5'b0, aluAndResetFlags[7:3]});
      doReset(CSOR_RST_CMPW);
      chk("status upper", 10'h0a, {5'b0, aluAndResetFlags[7:3]});
      finalReport();
   end
endmodule
